// *** src/adcmc_pkg.sv ***
package adcmc_pkg;

   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FAST_CONV_HZ = 512_000;
   localparam int unsigned SLOW_CONV_HZ = 131_000;
   // nearest whole divisor of the system clock
   localparam int unsigned FAST_DIV =
      (CLK_HZ + FAST_CONV_HZ / 2) / FAST_CONV_HZ;
   localparam int unsigned SLOW_DIV =
      (CLK_HZ + SLOW_CONV_HZ / 2) / SLOW_CONV_HZ;
   localparam int unsigned DIV_W = 7;
   localparam logic [DIV_W-1:0] FAST_RELOAD = DIV_W'(FAST_DIV - 1);
   localparam logic [DIV_W-1:0] SLOW_RELOAD = DIV_W'(SLOW_DIV - 1);

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [31:0] ADDR_STATUS = 32'hFFFF_0500;
   localparam logic [31:0] ADDR_MASK = 32'hFFFF_0504;
   localparam logic [31:0] ADDR_MODE = 32'hFFFF_0508;
   localparam logic [31:0] ADDR_PRI_RESULT = 32'hFFFF_0510;
   localparam logic [31:0] ADDR_AUX_RESULT = 32'hFFFF_0514;

   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h03;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [23:0] RESULT_RESET = 24'h000000;
   // implemented bits; reserved bits store nothing and read as zero
   localparam logic [7:0] MASK_IMPL = 8'h5B;
   localparam logic [7:0] MODE_IMPL = 8'hBF;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_ACC_THRESH = 6;
   localparam int unsigned BIT_CMP_THRESH = 4;
   localparam int unsigned BIT_OVERRANGE = 3;
   localparam int unsigned BIT_AUX_READY = 1;
   localparam int unsigned BIT_PRI_READY = 0;
   localparam int unsigned MODE_CLKSEL_BIT = 7;
   localparam int unsigned MODE_LPEN_BIT = 5;
   localparam int unsigned MODE_CFG_MSB = 4;
   localparam int unsigned MODE_CFG_LSB = 3;
   localparam int unsigned MODE_OP_MSB = 2;
   localparam int unsigned MODE_OP_LSB = 0;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PCFG_NORMAL = 2'h0,
      PCFG_LOW = 2'h1,
      PCFG_NORMAL_ALT = 2'h2,
      PCFG_LOW_PGA_OFF = 2'h3
   } adcmc_pcfg_t;

   typedef enum logic [2:0] {
      OP_POWER_DOWN = 3'h0,
      OP_CONTINUOUS = 3'h1,
      OP_SINGLE = 3'h2,
      OP_IDLE = 3'h3,
      OP_CAL_SELF_OFFSET = 3'h4,
      OP_CAL_SELF_GAIN = 3'h5,
      OP_CAL_SYS_ZERO = 3'h6,
      OP_CAL_SYS_FULL = 3'h7
   } adcmc_op_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pri_valid;
      logic aux_valid;
      logic cal_done;
      logic single_done;
      logic acc_thresh;
      logic cmp_thresh;
      logic ovr_detect;
      logic ovr_clear;
   } adcmc_evt_t;

   typedef struct packed {
      logic clk_fast;
      logic low_power;
      logic pga_off;
      logic lp_bias_on;
      logic power_down;
      logic held_in_reset;
      logic continuous;
      logic single;
      logic cal_run;
      logic [2:0] op;
   } adcmc_ctrl_t;

endpackage

// *** src/adcmc_mode_dec.sv ***
`timescale 1ns/10ps
module adcmc_mode_dec (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // raw mode register
   input wire logic [7:0] mode,
   // decoded controls
   output adcmc_pkg::adcmc_ctrl_t ctrl
);

   adcmc_pkg::adcmc_ctrl_t ctrl_r;
   adcmc_pkg::adcmc_ctrl_t ctrl_nxt;
   logic [1:0] cfg;
   logic [2:0] op;
   logic lp_sel;

   assign cfg = mode[adcmc_pkg::MODE_CFG_MSB:adcmc_pkg::MODE_CFG_LSB];
   assign op = mode[adcmc_pkg::MODE_OP_MSB:adcmc_pkg::MODE_OP_LSB];
   // 00 and 10 are both normal mode
   assign lp_sel = (cfg == adcmc_pkg::PCFG_LOW) ||
                   (cfg == adcmc_pkg::PCFG_LOW_PGA_OFF);

   always_comb begin
      ctrl_nxt = '0;
      ctrl_nxt.clk_fast = mode[adcmc_pkg::MODE_CLKSEL_BIT];
      ctrl_nxt.low_power = lp_sel;
      ctrl_nxt.pga_off = (cfg == adcmc_pkg::PCFG_LOW_PGA_OFF);
      // enable bit ignored in normal configurations
      ctrl_nxt.lp_bias_on = lp_sel & mode[adcmc_pkg::MODE_LPEN_BIT];
      ctrl_nxt.op = op;
      case (op)
         adcmc_pkg::OP_POWER_DOWN: begin
            ctrl_nxt.power_down = 1'b1;
            ctrl_nxt.pga_off = 1'b1;
         end
         adcmc_pkg::OP_CONTINUOUS: ctrl_nxt.continuous = 1'b1;
         adcmc_pkg::OP_SINGLE: ctrl_nxt.single = 1'b1;
         adcmc_pkg::OP_IDLE: ctrl_nxt.held_in_reset = 1'b1;
         default: ctrl_nxt.cal_run = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign ctrl = ctrl_r;

endmodule

// *** src/adcmc_top.sv ***
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module adcmc_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port
   input wire logic [31:0] BUS_ADDR,
   input wire logic [31:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   output logic [31:0] BUS_RDATA,
   // converter side
   input adcmc_pkg::adcmc_evt_t ANALOG_EVT,
   input wire logic [23:0] PRI_RESULT_DATA,
   input wire logic [23:0] AUX_RESULT_DATA,
   // controls to the converters
   output adcmc_pkg::adcmc_ctrl_t MODE_CTRL,
   output logic CONV_CLK_TICK,
   // interrupt request
   output logic ADC_IRQ
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [31:0] addr,
                                input logic [31:0] target);
      hit = (addr == target);
   endfunction

   function automatic logic is_cal(input logic [2:0] op);
      is_cal = op[2];
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   typedef enum {
      SEQ_IDLE,
      SEQ_SINGLE,
      SEQ_CAL
   } adcmc_seq_t;

   localparam int unsigned DIV_W_L = adcmc_pkg::DIV_W;

   adcmc_seq_t seq_r;
   adcmc_seq_t seq_nxt;
   logic [7:0] mask_r;
   logic [7:0] mode_r;
   logic acc_flag_r;
   logic cmp_flag_r;
   logic ovr_flag_r;
   logic aux_flag_r;
   logic pri_flag_r;
   logic aux_seen_r;
   logic [23:0] pri_result_r;
   logic [23:0] aux_result_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic irq_r;
   logic [DIV_W_L-1:0] div_r;
   logic clk_fast_d_r;
   logic tick_r;
   logic [7:0] status;
   logic wr_mask;
   logic wr_mode;
   logic rd_pri;
   logic rd_aux;
   logic pri_store;
   logic aux_store;
   logic seq_to_idle;
   logic [2:0] op_now;
   logic div_run;
   logic [DIV_W_L-1:0] div_reload;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign wr_mask = BUS_WR & hit(BUS_ADDR, adcmc_pkg::ADDR_MASK);
   assign wr_mode = BUS_WR & hit(BUS_ADDR, adcmc_pkg::ADDR_MODE);
   assign rd_pri = BUS_RD & hit(BUS_ADDR, adcmc_pkg::ADDR_PRI_RESULT);
   assign rd_aux = BUS_RD & hit(BUS_ADDR, adcmc_pkg::ADDR_AUX_RESULT);
   assign op_now = mode_r[adcmc_pkg::MODE_OP_MSB:adcmc_pkg::MODE_OP_LSB];

   // ----------------------------------------------------------------
   // interrupt mask register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mask_r <= adcmc_pkg::MASK_RESET;
      end else if (wr_mask) begin
         // reserved positions never store a value
         mask_r <= BUS_WDATA[7:0] & adcmc_pkg::MASK_IMPL;
      end
   end

   // ----------------------------------------------------------------
   // mode register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mode_r <= adcmc_pkg::MODE_RESET;
      end else if (wr_mode) begin
         mode_r <= BUS_WDATA[7:0] & adcmc_pkg::MODE_IMPL;
      end else if (seq_to_idle) begin
         // single shot or calibration over: fall back to idle
         mode_r[adcmc_pkg::MODE_OP_MSB:adcmc_pkg::MODE_OP_LSB] <=
            adcmc_pkg::OP_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // single shot and calibration sequencer
   // ----------------------------------------------------------------
   always_comb begin
      seq_nxt = seq_r;
      seq_to_idle = 1'b0;
      case (seq_r)
         SEQ_IDLE: begin
            if (op_now == adcmc_pkg::OP_SINGLE) begin
               seq_nxt = SEQ_SINGLE;
            end else if (is_cal(op_now)) begin
               seq_nxt = SEQ_CAL;
            end
         end
         SEQ_SINGLE: begin
            if (op_now != adcmc_pkg::OP_SINGLE) begin
               seq_nxt = SEQ_IDLE;
            end else if (ANALOG_EVT.single_done) begin
               seq_to_idle = 1'b1;
               seq_nxt = SEQ_IDLE;
            end
         end
         SEQ_CAL: begin
            if (!is_cal(op_now)) begin
               seq_nxt = SEQ_IDLE;
            end else if (ANALOG_EVT.cal_done) begin
               seq_to_idle = 1'b1;
               seq_nxt = SEQ_IDLE;
            end
         end
         default: seq_nxt = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         seq_r <= SEQ_IDLE;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // result registers
   // ----------------------------------------------------------------
   // new data lands only while the ready flag is clear or during a primary result read
   assign pri_store = ANALOG_EVT.pri_valid & (~pri_flag_r | rd_pri);
   assign aux_store = ANALOG_EVT.aux_valid & (~aux_flag_r | rd_pri);

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pri_result_r <= adcmc_pkg::RESULT_RESET;
      end else if (pri_store) begin
         pri_result_r <= PRI_RESULT_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         aux_result_r <= adcmc_pkg::RESULT_RESET;
      end else if (aux_store) begin
         aux_result_r <= AUX_RESULT_DATA;
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         pri_flag_r <= 1'b0;
      end else if (pri_store || ANALOG_EVT.cal_done) begin
         pri_flag_r <= 1'b1;
      end else if (rd_pri) begin
         pri_flag_r <= 1'b0;
      end
   end

   // auxiliary read arms the clear; the next primary read completes it
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         aux_seen_r <= 1'b0;
      end else if (rd_aux) begin
         aux_seen_r <= 1'b1;
      end else if (rd_pri) begin
         aux_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         aux_flag_r <= 1'b0;
      end else if (aux_store || ANALOG_EVT.cal_done) begin
         aux_flag_r <= 1'b1;
      end else if (rd_pri && aux_seen_r) begin
         aux_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ovr_flag_r <= 1'b0;
      end else if (ANALOG_EVT.ovr_detect) begin
         ovr_flag_r <= 1'b1;
      end else if (ANALOG_EVT.ovr_clear) begin
         ovr_flag_r <= 1'b0;
      end
   end

   // threshold flags follow the comparators
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         acc_flag_r <= 1'b0;
         cmp_flag_r <= 1'b0;
      end else begin
         acc_flag_r <= ANALOG_EVT.acc_thresh;
         cmp_flag_r <= ANALOG_EVT.cmp_thresh;
      end
   end

   always_comb begin
      status = adcmc_pkg::STATUS_RESET;
      status[adcmc_pkg::BIT_ACC_THRESH] = acc_flag_r;
      status[adcmc_pkg::BIT_CMP_THRESH] = cmp_flag_r;
      status[adcmc_pkg::BIT_OVERRANGE] = ovr_flag_r;
      status[adcmc_pkg::BIT_AUX_READY] = aux_flag_r;
      status[adcmc_pkg::BIT_PRI_READY] = pri_flag_r;
   end

   // ----------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <=
            (status[adcmc_pkg::BIT_ACC_THRESH] &
             mask_r[adcmc_pkg::BIT_ACC_THRESH]) |
            (status[adcmc_pkg::BIT_CMP_THRESH] &
             mask_r[adcmc_pkg::BIT_CMP_THRESH]) |
            (status[adcmc_pkg::BIT_OVERRANGE] &
             mask_r[adcmc_pkg::BIT_OVERRANGE]) |
            (status[adcmc_pkg::BIT_AUX_READY] &
             mask_r[adcmc_pkg::BIT_AUX_READY]) |
            (status[adcmc_pkg::BIT_PRI_READY] &
             mask_r[adcmc_pkg::BIT_PRI_READY]);
      end
   end

   assign ADC_IRQ = irq_r;

   // ----------------------------------------------------------------
   // conversion clock divider
   // ----------------------------------------------------------------
   assign div_reload = MODE_CTRL.clk_fast ? adcmc_pkg::FAST_RELOAD :
                                            adcmc_pkg::SLOW_RELOAD;
   // stopped in power-down
   assign div_run = ~MODE_CTRL.power_down;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         clk_fast_d_r <= 1'b0;
      end else begin
         clk_fast_d_r <= MODE_CTRL.clk_fast;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else if (!div_run || (clk_fast_d_r != MODE_CTRL.clk_fast)) begin
         div_r <= div_reload;
         tick_r <= 1'b0;
      end else if (div_r == '0) begin
         div_r <= div_reload;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r - DIV_W_L'(1);
         tick_r <= 1'b0;
      end
   end

   assign CONV_CLK_TICK = tick_r;

   // ----------------------------------------------------------------
   // register read-back
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = '0;
      if (BUS_RD) begin
         case (BUS_ADDR)
            adcmc_pkg::ADDR_STATUS: rdata_nxt = {24'h000000, status};
            adcmc_pkg::ADDR_MASK: rdata_nxt = {24'h000000, mask_r};
            adcmc_pkg::ADDR_MODE: rdata_nxt = {24'h000000, mode_r};
            adcmc_pkg::ADDR_PRI_RESULT:
               rdata_nxt = {8'h00, pri_result_r};
            adcmc_pkg::ADDR_AUX_RESULT:
               rdata_nxt = {8'h00, aux_result_r};
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign BUS_RDATA = rdata_r;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   adcmc_mode_dec u_mode_dec (
      .clk (CLK),
      .rst_b (RST_B),
      .mode (mode_r),
      .ctrl (MODE_CTRL)
   );

endmodule

// *** tb/adcmc_props.sv ***
`timescale 1ns/10ps
module adcmc_props (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port
   input wire logic [31:0] BUS_ADDR,
   input wire logic [31:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic [31:0] BUS_RDATA,
   // converter side
   input adcmc_pkg::adcmc_evt_t ANALOG_EVT,
   input wire logic [23:0] PRI_RESULT_DATA,
   input wire logic [23:0] AUX_RESULT_DATA,
   // controls and interrupt
   input adcmc_pkg::adcmc_ctrl_t MODE_CTRL,
   input wire logic CONV_CLK_TICK,
   input wire logic ADC_IRQ
);
   // ----------------------------------------------------------------
   // shadow state
   // ----------------------------------------------------------------
   logic [7:0] mask_r;
   logic [4:0] hi_r;
   logic [1:0] age_r;
   logic [7:0] gap_r;
   logic [7:0] quiet_r;
   logic live;
   logic mode_wr;
   assign live = (age_r == 2'h3);
   assign mode_wr = BUS_WR && (BUS_ADDR == adcmc_pkg::ADDR_MODE);

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mask_r <= adcmc_pkg::MASK_RESET;
      end else if (BUS_WR && BUS_ADDR == adcmc_pkg::ADDR_MASK) begin
         mask_r <= BUS_WDATA[7:0] & adcmc_pkg::MASK_IMPL;
      end
   end

   // upper mode fields are never touched by the sequencer
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         hi_r <= adcmc_pkg::MODE_RESET[7:3];
      end else if (mode_wr) begin
         hi_r <= BUS_WDATA[7:3];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         age_r <= 2'h0;
      end else if (!live) begin
         age_r <= age_r + 2'h1;
      end
   end

   // cycles since last tick, and since the last mode write or power-down
   always_ff @(posedge CLK) begin
      if (!RST_B || CONV_CLK_TICK) begin
         gap_r <= 8'h00;
      end else if (gap_r != 8'hFF) begin
         gap_r <= gap_r + 8'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B || mode_wr || MODE_CTRL.power_down) begin
         quiet_r <= 8'h00;
      end else if (quiet_r != 8'hFF) begin
         quiet_r <= quiet_r + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   a_rdata_idle: assert property (
      !$past(BUS_RD) |-> BUS_RDATA == 32'h0)
      else $error("read data not zero outside read slot");
   a_mask_read: assert property (
      live && $past(BUS_RD) && $past(BUS_ADDR) == adcmc_pkg::ADDR_MASK
      |-> BUS_RDATA == {24'h0, $past(mask_r)})
      else $error("mask readback wrong");
   a_irq_masked: assert property (
      live && $past(mask_r) == 8'h00 |-> !ADC_IRQ)
      else $error("interrupt with all sources masked");
   a_acc_irq: assert property (
      live && $past(ANALOG_EVT.acc_thresh, 2) && $past(mask_r[6])
      |-> ADC_IRQ)
      else $error("accumulator source did not interrupt");
   a_cmp_irq: assert property (
      live && $past(ANALOG_EVT.cmp_thresh, 2) && $past(mask_r[4])
      |-> ADC_IRQ)
      else $error("comparator source did not interrupt");
   a_ovr_irq: assert property (
      live && $past(ANALOG_EVT.ovr_detect, 2) && $past(mask_r[3])
      |-> ADC_IRQ)
      else $error("overrange source did not interrupt");
   a_aux_irq: assert property (
      live && $past(ANALOG_EVT.aux_valid, 2) && $past(mask_r[1])
      |-> ADC_IRQ)
      else $error("auxiliary ready did not interrupt");
   a_pri_irq: assert property (
      live && $past(ANALOG_EVT.pri_valid, 2) && $past(mask_r[0])
      |-> ADC_IRQ)
      else $error("primary ready did not interrupt");
   a_cal_ready: assert property (
      live && $past(ANALOG_EVT.cal_done, 2) && $past(mask_r[0])
      |-> ADC_IRQ)
      else $error("calibration end did not set ready");
   a_clk_select: assert property (
      live |-> MODE_CTRL.clk_fast == $past(hi_r[4]))
      else $error("conversion clock select wrong");
   a_tick_period: assert property (
      CONV_CLK_TICK && quiet_r > 8'h96
      |-> gap_r == (MODE_CTRL.clk_fast ? 8'h13 : 8'h4B))
      else $error("conversion tick period wrong");
   a_power_field: assert property (
      live && !MODE_CTRL.power_down
      |-> MODE_CTRL.low_power == $past(hi_r[0])
          && MODE_CTRL.pga_off == ($past(hi_r[0]) && $past(hi_r[1])))
      else $error("power configuration decode wrong");
   a_lp_enable: assert property (
      live && !MODE_CTRL.power_down
      |-> MODE_CTRL.lp_bias_on == ($past(hi_r[0]) && $past(hi_r[2])))
      else $error("low power enable decode wrong");
   a_power_down: assert property (
      MODE_CTRL.power_down [*2] |-> MODE_CTRL.pga_off && !CONV_CLK_TICK)
      else $error("power down leaves circuits running");
endmodule

bind adcmc_top adcmc_props u_props (.CLK(CLK), .RST_B(RST_B),
   .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR),
   .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .ANALOG_EVT(ANALOG_EVT),
   .PRI_RESULT_DATA(PRI_RESULT_DATA), .AUX_RESULT_DATA(AUX_RESULT_DATA),
   .MODE_CTRL(MODE_CTRL), .CONV_CLK_TICK(CONV_CLK_TICK),
   .ADC_IRQ(ADC_IRQ));

// *** tb/tb_adcmc_top.sv ***
`timescale 1ns/10ps
module tb_adcmc_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk;
   logic rst_b;
   logic [31:0] bus_addr;
   logic [31:0] bus_wdata;
   logic bus_wr;
   logic bus_rd;
   logic [31:0] rdata;
   adcmc_pkg::adcmc_evt_t evt;
   logic [23:0] pri_data;
   logic [23:0] aux_data;
   adcmc_pkg::adcmc_ctrl_t ctrl;
   logic tick;
   logic irq;
   logic [31:0] rd_val;
   int error_cnt;
   int checks_done;
   // mask bit and event bit of each interrupt source
   logic [7:0] src_mask [5] = '{8'h40, 8'h10, 8'h08, 8'h02, 8'h01};
   logic [7:0] src_evt [5] = '{8'h08, 8'h04, 8'h02, 8'h40, 8'h80};

   adcmc_top u_dut (.CLK(clk), .RST_B(rst_b), .BUS_ADDR(bus_addr),
      .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
      .BUS_RDATA(rdata), .ANALOG_EVT(evt), .PRI_RESULT_DATA(pri_data),
      .AUX_RESULT_DATA(aux_data), .MODE_CTRL(ctrl),
      .CONV_CLK_TICK(tick), .ADC_IRQ(irq));

   always #50 clk = ~clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task stop_test;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task rd_chk(input string n, input logic [31:0] a, input logic [31:0] e);
      rd(a, rd_val);
      chk(n, e, rd_val);
   endtask

   // one-cycle pulse; the threshold levels stay up
   task pulse(input logic [7:0] v);
      @(posedge clk);
      evt <= adcmc_pkg::adcmc_evt_t'(v);
      @(posedge clk);
      evt <= adcmc_pkg::adcmc_evt_t'(v & 8'h0C);
   endtask

   task irq_chk(input logic e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   task clear_all;
      pulse(8'h01);
      rd(adcmc_pkg::ADDR_AUX_RESULT, rd_val);
      rd(adcmc_pkg::ADDR_PRI_RESULT, rd_val);
   endtask

   task set_mode(input logic [7:0] m);
      wr(adcmc_pkg::ADDR_MODE, {24'h0, m});
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_regs;
      rd_chk("mask reset", adcmc_pkg::ADDR_MASK, 32'h0);
      rd_chk("mode reset", adcmc_pkg::ADDR_MODE, 32'h03);
      chk("op reset", 32'h3, {29'h0, ctrl.op});
      chk("held reset", 32'h1, {31'h0, ctrl.held_in_reset});
      wr(adcmc_pkg::ADDR_MASK, 32'hFFFF_FFFF);
      rd_chk("mask bits", adcmc_pkg::ADDR_MASK, 32'h5B);
      wr(adcmc_pkg::ADDR_MASK, 32'hA4);
      rd_chk("mask reserved", adcmc_pkg::ADDR_MASK, 32'h0);
      pulse(8'hCE);
      irq_chk(1'b0);
      clear_all;
      wr(adcmc_pkg::ADDR_MODE, 32'hFF);
      rd_chk("mode bits", adcmc_pkg::ADDR_MODE, 32'hBF);
      wr(32'hFFFF_0600, 32'hFF);
      rd_chk("unmapped", 32'hFFFF_0600, 32'h0);
      rd_chk("mask kept", adcmc_pkg::ADDR_MASK, 32'h0);
   endtask

   task t_sources;
      for (int k = 0; k < 5; k++) begin
         wr(adcmc_pkg::ADDR_MASK, {24'h0, 8'h5B & ~src_mask[k]});
         pulse(src_evt[k]);
         irq_chk(1'b0);
         wr(adcmc_pkg::ADDR_MASK, {24'h0, src_mask[k]});
         irq_chk(1'b1);
         rd_chk("status", adcmc_pkg::ADDR_STATUS,
                {24'h0, src_mask[k]});
         if (k == 3) begin
            rd_chk("aux data", adcmc_pkg::ADDR_AUX_RESULT, 32'h3C0F81);
         end
         if (k == 4) begin
            rd_chk("pri data", adcmc_pkg::ADDR_PRI_RESULT, 32'hC35A96);
         end
         clear_all;
         irq_chk(1'b0);
         // event with its source already enabled
         pulse(src_evt[k]);
         irq_chk(1'b1);
         clear_all;
      end
   endtask

   task t_cal;
      wr(adcmc_pkg::ADDR_MASK, 32'h01);
      wr(adcmc_pkg::ADDR_MODE, 32'h04);
      @(posedge clk);
      pulse(8'h20);
      irq_chk(1'b1);
      rd_chk("mode after cal", adcmc_pkg::ADDR_MODE, 32'h03);
      clear_all;
      wr(adcmc_pkg::ADDR_MODE, 32'h02);
      @(posedge clk);
      pulse(8'h10);
      rd_chk("mode after single", adcmc_pkg::ADDR_MODE, 32'h03);
   endtask

   task t_modes;
      for (int op = 0; op < 8; op++) begin
         set_mode(8'(op));
         chk("op", 32'(op), {29'h0, ctrl.op});
         chk("power down", 32'(op == 0), {31'h0, ctrl.power_down});
         chk("continuous", 32'(op == 1), {31'h0, ctrl.continuous});
         chk("single", 32'(op == 2), {31'h0, ctrl.single});
         chk("held", 32'(op == 3), {31'h0, ctrl.held_in_reset});
         chk("cal run", 32'(op > 3), {31'h0, ctrl.cal_run});
         chk("pga down", 32'(op == 0), {31'h0, ctrl.pga_off});
      end
   endtask

   task t_power;
      for (int c = 0; c < 8; c++) begin
         // enable held high in every low-power setting
         set_mode({2'h0, (c & 5) != 0, 2'(c), 3'h3});
         chk("low power", 32'(c % 2), {31'h0, ctrl.low_power});
         chk("pga off", 32'(c % 4 == 3), {31'h0, ctrl.pga_off});
         chk("lp bias", 32'(c % 2), {31'h0, ctrl.lp_bias_on});
      end
   endtask

   task period(output int n);
      n = 0;
      while (tick !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1 && n < 200);
   endtask

   task t_clk;
      int n;
      set_mode(8'h83);
      chk("clk fast", 32'h1, {31'h0, ctrl.clk_fast});
      period(n);
      chk("fast period", 32'h14, n);
      set_mode(8'h2B);
      chk("clk slow", 32'h0, {31'h0, ctrl.clk_fast});
      period(n);
      period(n);
      chk("slow period", 32'h4C, n);
      set_mode(8'h00);
      n = 0;
      repeat (200) begin
         @(negedge clk);
         n += int'(tick === 1'b1);
      end
      chk("ticks in power down", 32'h0, n);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      bus_addr = 32'h0;
      bus_wdata = 32'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      evt = '0;
      pri_data = 24'hC35A96;
      aux_data = 24'h3C0F81;
      error_cnt = 0;
      checks_done = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_sources;
      t_cal;
      t_modes;
      t_power;
      t_clk;
      stop_test;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      stop_test;
   end
endmodule
